// >>> src/heater_loop_pkg.sv
// Shared types and constants for the heater control loop
package heater_loop_pkg;

   // Output modes; off, closed loop, zone and open loop are the core four
   typedef enum logic [2:0] {
      MODE_OFF     = 3'b000,
      MODE_CLOSED  = 3'b001,
      MODE_ZONE    = 3'b010,
      MODE_OPEN    = 3'b011,
      MODE_MONITOR = 3'b100,
      MODE_WARMUP  = 3'b101
   } output_mode_command_t;

   // Feedback source selector
   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_A    = 3'b001,
      SRC_B    = 3'b010,
      SRC_C    = 3'b011,
      SRC_D    = 3'b100
   } feedSrc_t;

   // Field widths
   localparam int GAIN_W  = 14;   // Gain and integral in tenths, 0..10000
   localparam int DPCT_W  = 8;    // Derivative percent, 0..200
   localparam int MAN_W   = 14;   // Manual output in 0.01 %, 0..10000
   localparam int RANGE_W = 3;    // Heater range code, 0 is off
   localparam int TEMP_W  = 16;   // Sensor reading and setpoint
   localparam int ZIDX_W  = 4;    // Zone index
   localparam int ZONES   = 10;   // Number of zones

   // Tuning set, as written by command or taken from the zone table
   typedef struct packed {
      logic [GAIN_W-1:0] pGain;
      logic [GAIN_W-1:0] iGain;
      logic [DPCT_W-1:0] dPct;
   } tuning_t;

   // output_mode_command: mode and feedback source
   typedef struct packed {
      logic     valid;
      output_mode_command_t mode;
      feedSrc_t source;
   } modeCmd_t;

   // heater_setup_command: heater range
   typedef struct packed {
      logic               valid;
      logic [RANGE_W-1:0] range;
   } heaterCmd_t;

   // manual_output_command: manual output level
   typedef struct packed {
      logic             valid;
      logic [MAN_W-1:0] value;
   } manualCmd_t;

   // Tuning write
   typedef struct packed {
      logic    valid;
      tuning_t tuning;
   } tuneCmd_t;

   // Zone table write: upper setpoint bound and tuning of one zone
   typedef struct packed {
      logic              valid;
      logic [ZIDX_W-1:0] idx;
      logic [TEMP_W-1:0] bound;
      tuning_t           tuning;
   } zoneWr_t;

   // Four sensor readings with a common sample strobe
   typedef struct packed {
      logic              valid;
      logic [TEMP_W-1:0] a;
      logic [TEMP_W-1:0] b;
      logic [TEMP_W-1:0] c;
      logic [TEMP_W-1:0] d;
   } sensors_t;

   // Limits and reset values
   localparam logic [GAIN_W-1:0]  P_MAX    = 14'h2710;  // 1000.0
   localparam logic [GAIN_W-1:0]  P_RESET  = 14'h01F4;  // 50.0
   localparam logic [GAIN_W-1:0]  I_MAX    = 14'h2710;  // 1000.0
   localparam logic [GAIN_W-1:0]  I_RESET  = 14'h00C8;  // 20.0
   localparam logic [GAIN_W-1:0]  I_OFF    = 14'h0000;  // Integral off
   localparam logic [DPCT_W-1:0]  D_MAX    = 8'hC8;     // 200 %
   localparam logic [DPCT_W-1:0]  D_RESET  = 8'h00;     // 0 %
   localparam logic [MAN_W-1:0]   MAN_MAX  = 14'h2710;  // 100.00 %
   localparam logic [MAN_W-1:0]   MAN_ZERO = 14'h0000;
   localparam logic [RANGE_W-1:0] RANGE_OFF = 3'h0;

   // Derivative time is dPct % of a quarter of 1000/I seconds with I in
   // tenths: Td = dPct * 25 / iGain
   localparam logic signed [7:0]  D_QUARTER = 8'sh19;

   // Arithmetic scaling
   localparam int INTEG_SHIFT = 8;
   localparam int OUT_SHIFT   = 10;
   localparam int MON_SHIFT   = 2;
   localparam logic signed [33:0] INTEG_LIM = 34'sh0_3FFF_FFFF;

endpackage : heater_loop_pkg

// >>> src/zone_param_mem.sv
// Zone tuning table, one tuning set per zone, registered read
`timescale 1ns/1ps
module zone_param_mem (
   // Clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   // Write port
   input  wire logic                                wrEn,
   input  wire logic [heater_loop_pkg::ZIDX_W-1:0]  wrAddr,
   input  wire heater_loop_pkg::tuning_t            wrData,
   // Read port
   input  wire logic [heater_loop_pkg::ZIDX_W-1:0]  rdAddr,
   output heater_loop_pkg::tuning_t                 rdData
);

   // Storage and read register held as one state struct
   typedef struct packed {
      heater_loop_pkg::tuning_t [heater_loop_pkg::ZONES-1:0] mem;
      heater_loop_pkg::tuning_t                              rd;
   } memState_t;

   memState_t st;       // Current state
   memState_t next_st;  // Next state

   // Write and read address decode
   always_comb begin
      next_st = st;
      if (wrEn && (wrAddr < heater_loop_pkg::ZIDX_W'(heater_loop_pkg::ZONES))) begin
         next_st.mem[wrAddr] = wrData;
      end
      // Out-of-range reads return the last entry
      if (rdAddr < heater_loop_pkg::ZIDX_W'(heater_loop_pkg::ZONES)) begin
         next_st.rd = st.mem[rdAddr];
      end else begin
         next_st.rd = st.mem[heater_loop_pkg::ZONES-1];
      end
   end

   // Table resets to the power-on tuning
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int k = 0; k < heater_loop_pkg::ZONES; k++) begin
            st.mem[k] <= '{heater_loop_pkg::P_RESET,
                           heater_loop_pkg::I_RESET,
                           heater_loop_pkg::D_RESET};
         end
         st.rd <= '{heater_loop_pkg::P_RESET, heater_loop_pkg::I_RESET,
                    heater_loop_pkg::D_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign rdData = st.rd;

endmodule // zone_param_mem

// >>> src/heater_pid_loop_control.sv
// Heater output control loop: mode logic, three-term control and zones
`timescale 1ns/1ps
module heater_pid_loop_control #(
   parameter int OUT_NUMBER = 1   // Output number, 1 to 4
) (
   // Clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   // Commands
   input  wire heater_loop_pkg::modeCmd_t           modeCmd,
   input  wire heater_loop_pkg::heaterCmd_t         heaterCmd,
   input  wire heater_loop_pkg::manualCmd_t         manualCmd,
   input  wire heater_loop_pkg::tuneCmd_t           tuneCmd,
   input  wire heater_loop_pkg::zoneWr_t            zoneWr,
   // Process inputs
   input  wire heater_loop_pkg::sensors_t           sensors,
   input  wire logic [heater_loop_pkg::TEMP_W-1:0]  setpoint,
   // Drive and status
   output logic [heater_loop_pkg::MAN_W-1:0]        drive,
   output logic                                     driveOn,
   output logic                                     loopActive,
   output heater_loop_pkg::output_mode_command_t                modeNow,
   output heater_loop_pkg::feedSrc_t                sourceNow,
   output logic [heater_loop_pkg::RANGE_W-1:0]      rangeNow,
   output logic [heater_loop_pkg::MAN_W-1:0]        manualNow,
   output heater_loop_pkg::tuning_t                 tuningNow,
   output logic [heater_loop_pkg::ZIDX_W-1:0]       zoneNow
);

   // Reset feedback source depends on the output number
   localparam heater_loop_pkg::feedSrc_t SRC_RESET =
      (OUT_NUMBER == 1) ? heater_loop_pkg::SRC_A :
      (OUT_NUMBER == 2) ? heater_loop_pkg::SRC_B :
                          heater_loop_pkg::SRC_NONE;

   // Whole state of the loop
   typedef struct packed {
      heater_loop_pkg::output_mode_command_t                mode;     // Output mode
      heater_loop_pkg::feedSrc_t                source;   // Feedback source
      logic [heater_loop_pkg::RANGE_W-1:0]      range;    // Heater range
      logic [heater_loop_pkg::MAN_W-1:0]        manual;   // Manual output
      heater_loop_pkg::tuning_t                 tune;     // Active tuning
      logic signed [33:0]                       integ;    // Integral sum
      logic signed [17:0]                       prevErr;  // Last error
      logic [heater_loop_pkg::MAN_W-1:0]        drive;    // Drive level
      logic                                     driveOn;  // Drive enabled
      logic                                     loopOk;   // Loop running
      logic [heater_loop_pkg::ZIDX_W-1:0]       zone;     // Current zone
      logic                                     zoneLoad; // Table read due
      logic [heater_loop_pkg::ZONES-1:0][heater_loop_pkg::TEMP_W-1:0] bound;
   } state_t;

   state_t st;       // Current state
   state_t next_st;  // Next state

   heater_loop_pkg::tuning_t             zoneTune;   // Table read data
   logic [heater_loop_pkg::ZIDX_W-1:0]   zoneCalc;   // Zone of setpoint
   logic [heater_loop_pkg::TEMP_W-1:0]   reading;    // Selected sensor
   logic signed [17:0]                   err;        // Setpoint - reading
   logic signed [18:0]                   dErr;       // Error change
   logic signed [33:0]                   integSum;   // Updated integral
   logic signed [33:0]                   integStep;  // err * I
   logic signed [33:0]                   dNum;       // dErr * D% * 25
   logic signed [33:0]                   dTerm;      // Derivative term
   logic signed [35:0]                   termSum;    // Sum of three terms
   logic signed [51:0]                   pidOut;     // Scaled by gain
   logic signed [51:0]                   total;      // Plus manual output
   logic [heater_loop_pkg::MAN_W-1:0]    loopDrive;  // Clamped loop drive
   logic [heater_loop_pkg::MAN_W-1:0]    monDrive;   // Monitor drive
   logic                                 isLoopMode; // Mode needs a loop
   logic                                 hasSensor;  // Source assigned

   // Zone tuning table
   zone_param_mem u_zone_mem (
      .core_clk (core_clk),
      .rst      (rst),
      .wrEn     (zoneWr.valid),
      .wrAddr   (zoneWr.idx),
      .wrData   (zoneWr.tuning),
      .rdAddr   (zoneCalc),
      .rdData   (zoneTune)
   );

   // Feedback sensor selection and zone lookup
   always_comb begin
      case (st.source)
         heater_loop_pkg::SRC_A: reading = sensors.a;
         heater_loop_pkg::SRC_B: reading = sensors.b;
         heater_loop_pkg::SRC_C: reading = sensors.c;
         heater_loop_pkg::SRC_D: reading = sensors.d;
         default:                reading = '0;
      endcase
      // First zone whose upper bound holds the setpoint, else the last
      zoneCalc = heater_loop_pkg::ZIDX_W'(heater_loop_pkg::ZONES - 1);
      for (int k = heater_loop_pkg::ZONES - 1; k >= 0; k--) begin
         if (setpoint <= st.bound[k]) begin
            zoneCalc = heater_loop_pkg::ZIDX_W'(k);
         end
      end
   end

   // Three-term computation, shared by closed loop, zone and warm-up modes
   always_comb begin
      err = 18'(signed'({2'b00, setpoint})) -
            18'(signed'({2'b00, reading}));
      dErr = 19'(err) - 19'(st.prevErr);
      // Integral per sample is err times the 1000/seconds setting
      integStep = 34'(err) * 34'(signed'({1'b0, st.tune.iGain}));
      integSum  = st.integ + integStep;
      if (integSum > heater_loop_pkg::INTEG_LIM) begin
         integSum = heater_loop_pkg::INTEG_LIM;
      end else if (integSum < -heater_loop_pkg::INTEG_LIM) begin
         integSum = -heater_loop_pkg::INTEG_LIM;
      end
      // Derivative time derived from I each sample, so it follows I
      dNum = 34'(dErr) * 34'(signed'({1'b0, st.tune.dPct})) *
             34'(heater_loop_pkg::D_QUARTER);
      if (st.tune.iGain == heater_loop_pkg::I_OFF) begin
         dTerm = '0;
      end else begin
         dTerm = dNum / 34'(signed'({1'b0, st.tune.iGain}));
      end
      termSum = 36'(err) + 36'(st.integ >>> heater_loop_pkg::INTEG_SHIFT)
                + 36'(dTerm);
      pidOut = (52'(termSum) * 52'(signed'({1'b0, st.tune.pGain})))
               >>> heater_loop_pkg::OUT_SHIFT;
      total = pidOut + 52'(signed'({1'b0, st.manual}));
      // Clamp between zero and full scale
      if (total < 52'sd0) begin
         loopDrive = heater_loop_pkg::MAN_ZERO;
      end else if (total > 52'(signed'({1'b0, heater_loop_pkg::MAN_MAX})))
      begin
         loopDrive = heater_loop_pkg::MAN_MAX;
      end else begin
         loopDrive = total[heater_loop_pkg::MAN_W-1:0];
      end
      // Monitor drive is the selected reading scaled and clamped
      if ((reading >> heater_loop_pkg::MON_SHIFT) >
          heater_loop_pkg::TEMP_W'(heater_loop_pkg::MAN_MAX)) begin
         monDrive = heater_loop_pkg::MAN_MAX;
      end else begin
         monDrive = heater_loop_pkg::MAN_W'(
                       reading >> heater_loop_pkg::MON_SHIFT);
      end
   end

   // Command handling, mode logic and drive update
   always_comb begin
      next_st = st;
      // Mode and source command; open loop allowed on every output
      if (modeCmd.valid) begin
         next_st.mode   = modeCmd.mode;
         next_st.source = modeCmd.source;
      end
      if (heaterCmd.valid) begin
         next_st.range = heaterCmd.range;
      end
      // Manual output is limited to full scale
      if (manualCmd.valid) begin
         if (manualCmd.value > heater_loop_pkg::MAN_MAX) begin
            next_st.manual = heater_loop_pkg::MAN_MAX;
         end else begin
            next_st.manual = manualCmd.value;
         end
      end
      // Tuning write, each field limited to its span
      if (tuneCmd.valid) begin
         next_st.tune.pGain = (tuneCmd.tuning.pGain > heater_loop_pkg::P_MAX)
                              ? heater_loop_pkg::P_MAX
                              : tuneCmd.tuning.pGain;
         next_st.tune.iGain = (tuneCmd.tuning.iGain > heater_loop_pkg::I_MAX)
                              ? heater_loop_pkg::I_MAX
                              : tuneCmd.tuning.iGain;
         next_st.tune.dPct  = (tuneCmd.tuning.dPct > heater_loop_pkg::D_MAX)
                              ? heater_loop_pkg::D_MAX
                              : tuneCmd.tuning.dPct;
      end
      // Zone bound write
      if (zoneWr.valid &&
          (zoneWr.idx < heater_loop_pkg::ZIDX_W'(heater_loop_pkg::ZONES)))
      begin
         next_st.bound[zoneWr.idx] = zoneWr.bound;
      end
      // Zone crossing: read the table now, load it next cycle
      next_st.zoneLoad = 1'b0;
      if (st.mode == heater_loop_pkg::MODE_ZONE) begin
         if (zoneCalc != st.zone) begin
            next_st.zone     = zoneCalc;
            next_st.zoneLoad = 1'b1;
         end
      end else begin
         next_st.zone = zoneCalc;
      end
      // Zone table data override a tuning write in the same cycle
      if (st.zoneLoad && (st.mode == heater_loop_pkg::MODE_ZONE)) begin
         next_st.tune = zoneTune;
      end

      isLoopMode = (st.mode == heater_loop_pkg::MODE_CLOSED) ||
                   (st.mode == heater_loop_pkg::MODE_ZONE) ||
                   (st.mode == heater_loop_pkg::MODE_WARMUP);
      hasSensor  = (st.source != heater_loop_pkg::SRC_NONE);

      // Drive by mode; range off or mode off sources nothing
      next_st.loopOk = isLoopMode && hasSensor;
      if ((st.mode == heater_loop_pkg::MODE_OFF) ||
          (st.range == heater_loop_pkg::RANGE_OFF)) begin
         next_st.drive   = heater_loop_pkg::MAN_ZERO;
         next_st.driveOn = 1'b0;
         next_st.integ   = '0;
         next_st.prevErr = '0;
      end else begin
         case (st.mode)
            // Manual level only, feedback ignored
            heater_loop_pkg::MODE_OPEN: begin
               next_st.drive   = st.manual;
               next_st.driveOn = 1'b1;
            end
            // Output follows the selected sensor
            heater_loop_pkg::MODE_MONITOR: begin
               next_st.drive   = hasSensor ? monDrive
                                           : heater_loop_pkg::MAN_ZERO;
               next_st.driveOn = hasSensor;
            end
            // Closed loop, zone and warm-up share one computation
            heater_loop_pkg::MODE_CLOSED,
            heater_loop_pkg::MODE_ZONE,
            heater_loop_pkg::MODE_WARMUP: begin
               if (!hasSensor) begin
                  next_st.drive   = heater_loop_pkg::MAN_ZERO;
                  next_st.driveOn = 1'b0;
                  next_st.integ   = '0;
                  next_st.prevErr = '0;
               end else if (sensors.valid) begin
                  next_st.drive   = loopDrive;
                  next_st.driveOn = 1'b1;
                  next_st.integ   = integSum;
                  next_st.prevErr = err;
               end else begin
                  next_st.driveOn = 1'b1;
               end
            end
            // Unknown code turns the drive off; integral and last error are not cleared
            default: begin
               next_st.drive   = heater_loop_pkg::MAN_ZERO;
               next_st.driveOn = 1'b0;
            end
         endcase
      end
      if (next_st.tune.iGain == heater_loop_pkg::I_OFF) begin
         next_st.integ = '0;
      end
   end

   // State register with power-on reset values
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st          <= '0;
         st.mode     <= heater_loop_pkg::MODE_OFF;
         st.source   <= SRC_RESET;
         st.range    <= heater_loop_pkg::RANGE_OFF;
         st.manual   <= heater_loop_pkg::MAN_ZERO;
         st.tune     <= '{heater_loop_pkg::P_RESET,
                          heater_loop_pkg::I_RESET,
                          heater_loop_pkg::D_RESET};
      end else begin
         st <= next_st;
      end
   end

   // All outputs come from the state register
   assign drive      = st.drive;
   assign driveOn    = st.driveOn;
   assign loopActive = st.loopOk;
   assign modeNow    = st.mode;
   assign sourceNow  = st.source;
   assign rangeNow   = st.range;
   assign manualNow  = st.manual;
   assign tuningNow  = st.tune;
   assign zoneNow    = st.zone;

endmodule // heater_pid_loop_control

// >>> bench/heater_loop_monitor.sv
// Concurrent checks on the heater loop control ports
`timescale 1ns/1ps
module heater_loop_monitor (
   // Clock and reset
   input wire logic                       core_clk,
   input wire logic                       rst,
   // Inputs
   input wire heater_loop_pkg::tuneCmd_t  tuneCmd,
   input wire heater_loop_pkg::sensors_t  sensors,
   // Outputs
   input wire logic [13:0]                drive,
   input wire logic                       driveOn,
   input wire logic                       loopActive,
   input wire heater_loop_pkg::output_mode_command_t  modeNow,
   input wire heater_loop_pkg::feedSrc_t  sourceNow,
   input wire logic [2:0]                 rangeNow,
   input wire logic [13:0]                manualNow,
   input wire heater_loop_pkg::tuning_t   tuningNow,
   input wire logic [3:0]                 zoneNow
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [15:0] monA;   // Input A scaled and limited
   logic        inSpan; // Tuning write needs no clamping
   assign monA = (sensors.a >> 2) > 16'd10000 ? 16'd10000 : sensors.a >> 2;
   assign inSpan = tuneCmd.tuning.pGain <= heater_loop_pkg::P_MAX
      && tuneCmd.tuning.iGain <= heater_loop_pkg::I_MAX
      && tuneCmd.tuning.dPct <= heater_loop_pkg::D_MAX;
   off_no_drive_a: assert property (modeNow == heater_loop_pkg::MODE_OFF
      |=> drive == '0 && !driveOn) else $error("drive in off mode");
   range_off_a: assert property (rangeNow == '0
      |=> drive == '0 && !driveOn) else $error("drive with range off");
   open_manual_a: assert property (modeNow == heater_loop_pkg::MODE_OPEN
      && rangeNow != '0 |=> drive == $past(manualNow) && driveOn)
      else $error("open loop drive differs from manual");
   drive_clamp_a: assert property (drive <= heater_loop_pkg::MAN_MAX)
      else $error("drive above full scale");
   no_loop_src_a: assert property (sourceNow == heater_loop_pkg::SRC_NONE
      |=> !loopActive) else $error("loop active without sensor");
   loop_hold_a: assert property (modeNow == heater_loop_pkg::MODE_CLOSED
      && rangeNow != '0 && $stable(rangeNow) && $stable(modeNow)
      && sourceNow != heater_loop_pkg::SRC_NONE && !sensors.valid
      |=> $stable(drive)) else $error("loop drive moved without sample");
   mon_follow_a: assert property (modeNow == heater_loop_pkg::MODE_MONITOR
      && sourceNow == heater_loop_pkg::SRC_A && rangeNow != '0
      |=> drive == $past(monA[13:0])) else $error("monitor drive wrong");
   tuning_source_a: assert property ($changed(tuningNow)
      |-> $past(tuneCmd.valid) || $past(zoneNow) != $past(zoneNow, 2))
      else $error("tuning changed with no cause");
   tune_take_a: assert property (tuneCmd.valid && inSpan
      && modeNow != heater_loop_pkg::MODE_ZONE
      |=> tuningNow == $past(tuneCmd.tuning)) else $error("tuning not taken");
   open_c: cover property (modeNow == heater_loop_pkg::MODE_OPEN && driveOn);
   zone_c: cover property (modeNow == heater_loop_pkg::MODE_ZONE
      && $changed(zoneNow));
   mon_c: cover property (modeNow == heater_loop_pkg::MODE_MONITOR);
endmodule // heater_loop_monitor
bind heater_pid_loop_control heater_loop_monitor heater_loop_monitor_inst (
   .core_clk(core_clk), .rst(rst), .tuneCmd(tuneCmd), .sensors(sensors),
   .drive(drive), .driveOn(driveOn), .loopActive(loopActive),
   .modeNow(modeNow), .sourceNow(sourceNow), .rangeNow(rangeNow),
   .manualNow(manualNow), .tuningNow(tuningNow), .zoneNow(zoneNow));

// >>> bench/sensor_feed_model.sv
// Sensor source model: four readings with a periodic sample strobe
`timescale 1ns/1ps
module sensor_feed_model (
   // Clock and reset
   input wire logic                   core_clk,
   input wire logic                   rst,
   // Level of input A and cycles between samples
   input wire logic [15:0]            level,
   input wire logic [7:0]             gap,
   // Readings
   output heater_loop_pkg::sensors_t  sensors
);
   logic [7:0] count; // Cycles since last sample
   // Sample spacing counter, small gap answers promptly, large slowly
   always_ff @(posedge core_clk) begin
      count <= (rst || count >= gap) ? 8'h00 : count + 8'h01;
   end
   // Inputs B to D sit a few counts above A
   assign sensors = '{!rst && count == gap, level, level + 16'h0004,
                      level + 16'h0008, level + 16'h000c};
endmodule // sensor_feed_model

// >>> bench/heater_pid_loop_control_test.sv
// Self-checking bench of the heater loop control block
`timescale 1ns/1ps
module heater_pid_loop_control_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   heater_loop_pkg::modeCmd_t   modeCmd = '0;
   heater_loop_pkg::heaterCmd_t heaterCmd = '0;
   heater_loop_pkg::manualCmd_t manualCmd = '0;
   heater_loop_pkg::tuneCmd_t   tuneCmd = '0;
   heater_loop_pkg::zoneWr_t    zoneWr = '0;
   heater_loop_pkg::sensors_t   sensors;
   logic [15:0] setpoint = '0, level = '0;
   logic [7:0]  gap = 8'h03;
   logic [13:0] drive, manualNow;
   logic        driveOn, loopActive;
   heater_loop_pkg::output_mode_command_t modeNow;
   heater_loop_pkg::feedSrc_t sourceNow;
   logic [2:0]  rangeNow;
   heater_loop_pkg::tuning_t tuningNow;
   logic [3:0]  zoneNow;
   typedef struct {logic [2:0] sel; logic [35:0] val;} note_t;
   note_t notes[$]; // Expected results, oldest first
   event look;
   int num_errors = 0, checked = 0, cycles = 0;
   logic [31:0] rnd = 32'h0000_25eb;
   always #12.5 core_clk = ~core_clk;
   heater_pid_loop_control #(.OUT_NUMBER(1)) heater_pid_loop_control_inst (
      .core_clk(core_clk), .rst(rst), .modeCmd(modeCmd),
      .heaterCmd(heaterCmd), .manualCmd(manualCmd), .tuneCmd(tuneCmd),
      .zoneWr(zoneWr), .sensors(sensors), .setpoint(setpoint),
      .drive(drive), .driveOn(driveOn), .loopActive(loopActive),
      .modeNow(modeNow), .sourceNow(sourceNow), .rangeNow(rangeNow),
      .manualNow(manualNow), .tuningNow(tuningNow), .zoneNow(zoneNow));
   sensor_feed_model sensor_feed_model_inst (.core_clk(core_clk), .rst(rst),
      .level(level), .gap(gap), .sensors(sensors));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic want(input logic [2:0] sel, input logic [35:0] val);
      notes.push_back('{sel, val});
      -> look;
      #1;
   endtask
   // Watcher: takes each note and compares the chosen output
   always @(look) begin
      note_t n;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.sel)
            3'd0: check(36'(drive), n.val);
            3'd1: check(36'(driveOn), n.val);
            3'd2: check(36'(loopActive), n.val);
            3'd3: check(36'(sourceNow), n.val);
            3'd4: check(36'(tuningNow), n.val);
            default: check(36'(zoneNow), n.val);
         endcase
      end
   end
   task automatic setMode(input logic [2:0] m, input logic [2:0] s);
      @(posedge core_clk) modeCmd <= {1'b1, m, s};
      @(posedge core_clk) modeCmd.valid <= 1'b0;
   endtask
   task automatic setRange(input logic [2:0] r);
      @(posedge core_clk) heaterCmd <= {1'b1, r};
      @(posedge core_clk) heaterCmd.valid <= 1'b0;
   endtask
   task automatic setManual(input logic [13:0] v);
      @(posedge core_clk) manualCmd <= {1'b1, v};
      @(posedge core_clk) manualCmd.valid <= 1'b0;
   endtask
   task automatic setTune(input logic [35:0] t);
      @(posedge core_clk) tuneCmd <= {1'b1, t};
      @(posedge core_clk) tuneCmd.valid <= 1'b0;
   endtask
   task automatic setZone(input logic [3:0] i, input logic [51:0] bt);
      @(posedge core_clk) zoneWr <= {1'b1, i, bt};
      @(posedge core_clk) zoneWr.valid <= 1'b0;
   endtask
   task automatic proc(input logic [15:0] sp, input logic [15:0] lv);
      @(posedge core_clk) setpoint <= sp;
      level <= lv;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Waits until the drive shows the result of one sample
   task automatic sampled;
      do @(negedge core_clk); while (sensors.valid !== 1'b1);
      @(negedge core_clk);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cuts a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         final_report;
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      settle(1);
      want(3, 1);
      want(4, {14'd500, 14'd200, 8'd0});
      want(1, 0);
      $display("reset test done");
      setRange(3'h1);
      setMode(3'd3, 3'd0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         proc(16'h0100, rnd[15:0]);
         setManual(14'(rnd % 10001));
         settle(2);
         want(0, 36'(rnd % 10001));
         want(2, 0);
      end
      setManual(14'h3fff);
      settle(2);
      want(0, 10000);
      setRange(3'h0);
      settle(2);
      want(0, 0);
      want(1, 0);
      $display("open loop test done");
      setRange(3'h2);
      setManual(14'd5000);
      setTune({14'd1024, 14'd0, 8'd0});
      proc(16'd2100, 16'd2000);
      setMode(3'd1, 3'd1);
      sampled;
      sampled;
      want(0, 5100);
      want(2, 1);
      proc(16'd11000, 16'd2000);
      sampled;
      sampled;
      want(0, 10000);
      proc(16'd2000, 16'd11000);
      sampled;
      sampled;
      want(0, 0);
      setMode(3'd0, 3'd1);
      setManual(14'd0);
      setTune({14'd1024, 14'd1, 8'd1});
      proc(16'd2256, 16'd2000);
      sampled;
      setMode(3'd1, 3'd1);
      sampled;
      want(0, 6656);
      sampled;
      want(0, 257);
      setTune({14'h3fff, 14'h3fff, 8'hff});
      settle(1);
      want(4, {14'd10000, 14'd10000, 8'd200});
      $display("closed loop test done");
      proc(16'd0, 16'd1000);
      for (int s = 0; s < 5; s++) begin
         setMode(3'd4, 3'(s));
         settle(2);
         want(3, s);
         want(0, s == 0 ? 0 : (1000 + 4 * (s - 1)) >> 2);
      end
      setMode(3'd5, 3'd0);
      settle(2);
      want(2, 0);
      want(0, 0);
      setMode(3'd5, 3'd1);
      settle(2);
      want(2, 1);
      $display("source test done");
      setZone(4'd0, {16'd1000, 14'd100, 14'd0, 8'd0});
      setZone(4'd1, {16'd2000, 14'd1024, 14'd0, 8'd0});
      setMode(3'd0, 3'd1);
      setManual(14'd5000);
      proc(16'd500, 16'd400);
      setMode(3'd2, 3'd1);
      setTune({14'd300, 14'd0, 8'd7});
      settle(6);
      want(4, {14'd300, 14'd0, 8'd7});
      gap <= 8'h09;
      proc(16'd1500, 16'd1400);
      settle(3);
      want(5, 1);
      want(4, {14'd1024, 14'd0, 8'd0});
      sampled;
      sampled;
      want(0, 5100);
      proc(16'd500, 16'd400);
      settle(3);
      want(4, {14'd100, 14'd0, 8'd0});
      $display("zone test done");
      final_report;
   end
endmodule // heater_pid_loop_control_test
